// *** rtl/cmac_pkg.sv ***
// Constants, field layouts and types of the multiply-accumulate slice.
// Assumes one 125 MHz clock and an AHB-Lite master that reaches the slice.
//
// Overview of operation
// - The slice works as one 36x36, four 18x18 or eight 9x9 multipliers.
// - The 36x36 arrangement delivers only the bare product.
// - Medium: 2 add/sub/acc stages, 1 sum; narrow: 4 add/sub, 2 sums.
// - Only one arrangement is active at a time and they never mix.
// - Basic mode: one shared clock, enable and reset, each optional.
// - Advanced mode: each stage has its own clock, enable and reset.
// - Operands come in parallel, shift or dynamic format.
// - The shift format is allowed only for operands narrower than 18 bits.
// - The shift format places a sample-and-shift chain on the operand inputs.
// - In MAC mode the output register is always used for feedback.
// - The accumulator is 52 bits wide; wider sums are built outside.
// - Asserting accumulator load puts the load value into the accumulator.

package cmac_pkg;

  // Register byte offsets.
  localparam logic [31:0] CMAC_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] CMAC_STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] CMAC_RES0_OFS = 32'h0000_0008;
  localparam logic [31:0] CMAC_RES1_OFS = 32'h0000_000C;

  // Control register fields.
  localparam int unsigned CMAC_CTRL_ARR_LSB = 0;
  localparam int unsigned CMAC_CTRL_FMT_LSB = 2;
  localparam int unsigned CMAC_CTRL_ADV_BIT = 4;
  localparam int unsigned CMAC_CTRL_MAC_BIT = 5;
  localparam int unsigned CMAC_CTRL_SGN_BIT = 6;
  localparam int unsigned CMAC_CTRL_UCE_BIT = 7;
  localparam int unsigned CMAC_CTRL_URST_BIT = 8;
  localparam int unsigned CMAC_CTRL_WID_LSB = 9;
  localparam int unsigned CMAC_CTRL_W = 16;
  localparam logic [15:0] CMAC_CTRL_RST = 16'h4800;

  // Status register fields.
  localparam int unsigned CMAC_STAT_ARR_LSB = 0;
  localparam int unsigned CMAC_STAT_SHF_BIT = 2;
  localparam int unsigned CMAC_STAT_REF_BIT = 4;
  localparam int unsigned CMAC_STAT_OVF0_BIT = 5;
  localparam int unsigned CMAC_STAT_OVF1_BIT = 6;

  // Datapath figures.
  localparam int unsigned CMAC_ACC_W = 52;
  localparam logic [6:0] CMAC_SHIFT_MAX_W = 7'h12;
  localparam int unsigned CMAC_OP_W = 72;
  localparam int unsigned CMAC_SAMPLE_W = 18;
  localparam int unsigned CMAC_SHIFT_DEPTH = 8;

  // Register stage indices.
  localparam int unsigned CMAC_STG_IN = 0;
  localparam int unsigned CMAC_STG_PIPE = 1;
  localparam int unsigned CMAC_STG_OUT = 2;
  localparam int unsigned CMAC_NSTG = 3;

  typedef enum logic [1:0] {
    CMAC_ARR_WIDE = 2'h0,
    CMAC_ARR_MED = 2'h1,
    CMAC_ARR_NAR = 2'h2
  } cmac_arr_t;

  typedef enum logic [1:0] {
    CMAC_FMT_PAR = 2'h0,
    CMAC_FMT_SHIFT = 2'h1,
    CMAC_FMT_DYN = 2'h2
  } cmac_fmt_t;

  typedef enum logic [1:0] {
    CMAC_BUS_IDLE = 2'h0,
    CMAC_BUS_RDWAIT = 2'h1
  } cmac_bus_st_t;

endpackage

// *** rtl/cmac_mul.sv ***
// One multiplier lane of selectable width, signed or unsigned.
// Assumes operands are presented by registers of the caller.
`timescale 1ns/1ps
`default_nettype none

module cmac_mul #(
  parameter int W = 9
) (
  // Operands and sign mode.
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic signed_i,
  // Product.
  output logic [2*W-1:0] prod_o
);

  logic signed [W:0] a_x;
  logic signed [W:0] b_x;
  logic signed [2*W+1:0] full;

  // One extra bit lets the same multiplier serve both number formats.
  assign a_x = {signed_i & a_i[W-1], a_i};
  assign b_x = {signed_i & b_i[W-1], b_i};
  assign full = a_x * b_x;
  assign prod_o = full[2*W-1:0];

endmodule

`default_nettype wire

// *** rtl/cmac_shift.sv ***
// Sample-and-shift chain that feeds operands like the taps of a filter.
// Assumes one clock; the caller supplies stage enable and reset.
`timescale 1ns/1ps
`default_nettype none

module cmac_shift #(
  parameter int W = 18,
  parameter int DEPTH = 8
) (
  // Clock and resets.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic srst_i,
  // Sample stream.
  input wire logic en_i,
  input wire logic [W-1:0] din_i,
  output logic [W*DEPTH-1:0] taps_o
);

  logic [W*DEPTH-1:0] chain_q;

  // Newest sample enters the lowest tap.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      chain_q <= '0;
    else if (srst_i)
      chain_q <= '0;
    else if (en_i)
      chain_q <= {chain_q[W*(DEPTH-1)-1:0], din_i};
  end

  assign taps_o = chain_q;

endmodule

`default_nettype wire

// *** rtl/cmac_top.sv ***
// Configurable multiply-accumulate slice with an AHB-Lite register port.
// Assumes fabric logic drives operands and controls synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module cmac_top (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Operands.
  input wire logic [71:0] a_data_i,
  input wire logic [71:0] b_data_i,
  input wire logic [17:0] shift_a_i,
  input wire logic [17:0] shift_b_i,
  input wire logic dyn_shift_sel_i,
  // Register controls.
  input wire logic ce_i,
  input wire logic srst_i,
  input wire logic [2:0] stage_ce_i,
  input wire logic [2:0] stage_rst_i,
  // Arithmetic controls.
  input wire logic [3:0] addsub_i,
  input wire logic [1:0] accum_load_i,
  input wire logic [51:0] load_value_port0_i,
  input wire logic [51:0] load_value_port1_i,
  // Results.
  output logic [71:0] result0_o,
  output logic [51:0] result1_o,
  output logic overflow0_o,
  output logic overflow1_o
);

  // Extends a 36- or 18-bit lane value to the 53-bit work width.
  function automatic logic [52:0] ext53(input logic [35:0] v,
                                        input logic wide,
                                        input logic s);
    logic [52:0] r;
    r = {17'h00000, v};
    if (wide)
      r[52:36] = {17{s & v[35]}};
    else
      r[52:18] = {35{s & v[17]}};
    return r;
  endfunction

  // Adds or subtracts two work-width values.
  function automatic logic [52:0] addsub(input logic [52:0] x,
                                         input logic [52:0] y,
                                         input logic sub);
    return sub ? x - y : x + y;
  endfunction

  // Spreads shift chain taps over the active lanes.
  function automatic logic [71:0] shift_lanes(input logic [143:0] t,
                                              input cmac_pkg::cmac_arr_t ar,
                                              input logic s);
    logic [71:0] r;
    r = '0;
    case (ar)
      cmac_pkg::CMAC_ARR_WIDE: r = {36'h0, {18{s & t[17]}}, t[17:0]};
      cmac_pkg::CMAC_ARR_MED: r = t[71:0];
      default:
        for (int k = 0; k < 8; k++)
          r[9*k +: 9] = t[18*k +: 9];
    endcase
    return r;
  endfunction

  // Register state.
  logic [15:0] ctrl_q;
  logic ref_q;
  logic ovf0_st_q;
  logic ovf1_st_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic hresp_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] rd_addr_q;
  cmac_pkg::cmac_bus_st_t bus_q;

  // Datapath state.
  logic [71:0] a_q;
  logic [71:0] b_q;
  logic [143:0] pipe_q;
  logic [71:0] res0_q;
  logic [51:0] res1_q;
  logic ovf0_q;
  logic ovf1_q;

  // Control field decode.
  cmac_pkg::cmac_arr_t arr;
  logic [1:0] fmt;
  logic adv;
  logic mac;
  logic sgn;
  logic use_ce;
  logic use_rst;
  logic [6:0] opw;
  logic shift_ok;
  logic shift_req;
  logic use_shift;
  logic refuse;
  logic [2:0] stg_ce;
  logic [2:0] stg_rst;

  // An unused encoding falls back to the wide arrangement, so exactly one
  // arrangement is in force.
  assign arr = (ctrl_q[1:0] == 2'h2) ? cmac_pkg::CMAC_ARR_NAR :
               (ctrl_q[1:0] == 2'h1) ? cmac_pkg::CMAC_ARR_MED :
               cmac_pkg::CMAC_ARR_WIDE;
  assign fmt = ctrl_q[cmac_pkg::CMAC_CTRL_FMT_LSB +: 2];
  assign adv = ctrl_q[cmac_pkg::CMAC_CTRL_ADV_BIT];
  assign mac = ctrl_q[cmac_pkg::CMAC_CTRL_MAC_BIT] &
               (arr == cmac_pkg::CMAC_ARR_MED);
  assign sgn = ctrl_q[cmac_pkg::CMAC_CTRL_SGN_BIT];
  assign use_ce = ctrl_q[cmac_pkg::CMAC_CTRL_UCE_BIT];
  assign use_rst = ctrl_q[cmac_pkg::CMAC_CTRL_URST_BIT];
  assign opw = ctrl_q[cmac_pkg::CMAC_CTRL_WID_LSB +: 7];

  // Operand format choice; a shift request on wide operands is refused and
  // parallel inputs are used.
  assign shift_ok = opw < cmac_pkg::CMAC_SHIFT_MAX_W;
  assign shift_req = (fmt == cmac_pkg::CMAC_FMT_SHIFT) |
                     ((fmt == cmac_pkg::CMAC_FMT_DYN) & dyn_shift_sel_i);
  assign use_shift = shift_req & shift_ok;
  assign refuse = shift_req & ~shift_ok;

  // Stage enables and resets: shared in basic mode, each optional,
  // independent in advanced mode. With one physical clock, a stage's
  // own clock is modelled as its own enable.
  genvar gs;
  generate
    for (gs = 0; gs < cmac_pkg::CMAC_NSTG; gs++)
    begin : g_stg
      assign stg_ce[gs] = adv ? stage_ce_i[gs] :
                          (use_ce ? ce_i : 1'b1);
      assign stg_rst[gs] = adv ? stage_rst_i[gs] :
                           (use_rst & srst_i);
    end
  endgenerate

  // Shift chains for both operands.
  logic [143:0] a_taps;
  logic [143:0] b_taps;
  logic [71:0] a_op;
  logic [71:0] b_op;

  cmac_shift #(
    .W(cmac_pkg::CMAC_SAMPLE_W),
    .DEPTH(cmac_pkg::CMAC_SHIFT_DEPTH)
  ) u_shift_a (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .srst_i(stg_rst[cmac_pkg::CMAC_STG_IN]),
    .en_i(stg_ce[cmac_pkg::CMAC_STG_IN] & use_shift),
    .din_i(shift_a_i),
    .taps_o(a_taps)
  );

  cmac_shift #(
    .W(cmac_pkg::CMAC_SAMPLE_W),
    .DEPTH(cmac_pkg::CMAC_SHIFT_DEPTH)
  ) u_shift_b (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .srst_i(stg_rst[cmac_pkg::CMAC_STG_IN]),
    .en_i(stg_ce[cmac_pkg::CMAC_STG_IN] & use_shift),
    .din_i(shift_b_i),
    .taps_o(b_taps)
  );

  // Operand selection ahead of the input registers.
  assign a_op = use_shift ? shift_lanes(a_taps, arr, sgn) : a_data_i;
  assign b_op = use_shift ? shift_lanes(b_taps, arr, sgn) : b_data_i;

  // Input register stage.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      a_q <= '0;
      b_q <= '0;
    end
    else if (stg_rst[cmac_pkg::CMAC_STG_IN])
    begin
      a_q <= '0;
      b_q <= '0;
    end
    else if (stg_ce[cmac_pkg::CMAC_STG_IN])
    begin
      a_q <= a_op;
      b_q <= b_op;
    end
  end

  // Multiplier lanes for all three arrangements.
  logic [71:0] prod_w;
  logic [143:0] prod_m;
  logic [143:0] prod_n;
  logic [143:0] pipe_d;

  cmac_mul #(
    .W(36)
  ) u_mul_wide (
    .a_i(a_q[35:0]),
    .b_i(b_q[35:0]),
    .signed_i(sgn),
    .prod_o(prod_w)
  );

  genvar gm;
  generate
    for (gm = 0; gm < 4; gm++)
    begin : g_med
      cmac_mul #(
        .W(18)
      ) u_mul (
        .a_i(a_q[18*gm +: 18]),
        .b_i(b_q[18*gm +: 18]),
        .signed_i(sgn),
        .prod_o(prod_m[36*gm +: 36])
      );
    end
    for (gm = 0; gm < 8; gm++)
    begin : g_nar
      cmac_mul #(
        .W(9)
      ) u_mul (
        .a_i(a_q[9*gm +: 9]),
        .b_i(b_q[9*gm +: 9]),
        .signed_i(sgn),
        .prod_o(prod_n[18*gm +: 18])
      );
    end
  endgenerate

  // Only the active arrangement's products enter the pipeline register.
  assign pipe_d = (arr == cmac_pkg::CMAC_ARR_WIDE) ? {72'h0, prod_w} :
                  (arr == cmac_pkg::CMAC_ARR_MED) ? prod_m : prod_n;

  // Pipeline register stage.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      pipe_q <= '0;
    else if (stg_rst[cmac_pkg::CMAC_STG_PIPE])
      pipe_q <= '0;
    else if (stg_ce[cmac_pkg::CMAC_STG_PIPE])
      pipe_q <= pipe_d;
  end

  // Medium: two add/sub stages, their sum and two accumulators.
  logic [52:0] med0;
  logic [52:0] med1;
  logic [52:0] med_sum;
  logic [52:0] acc0_sum;
  logic [52:0] acc1_sum;
  logic [52:0] acc0_nx;
  logic [52:0] acc1_nx;
  logic acc0_ovf;
  logic acc1_ovf;

  assign med0 = addsub(ext53(pipe_q[35:0], 1'b1, sgn),
                       ext53(pipe_q[71:36], 1'b1, sgn), addsub_i[0]);
  assign med1 = addsub(ext53(pipe_q[107:72], 1'b1, sgn),
                       ext53(pipe_q[143:108], 1'b1, sgn), addsub_i[1]);
  assign med_sum = med0 + med1;

  // The accumulators live in the output registers.
  assign acc0_sum = {sgn & res0_q[51], res0_q[51:0]} + med0;
  assign acc1_sum = {sgn & res1_q[51], res1_q} + med1;
  assign acc0_nx = accum_load_i[0] ?
                   {sgn & load_value_port0_i[51], load_value_port0_i} :
                   acc0_sum;
  assign acc1_nx = accum_load_i[1] ?
                   {sgn & load_value_port1_i[51], load_value_port1_i} :
                   acc1_sum;
  // A sum that leaves 52 bits must be widened by logic outside the slice.
  assign acc0_ovf = ~accum_load_i[0] &
                    (sgn ? acc0_sum[52] ^ acc0_sum[51] : acc0_sum[52]);
  assign acc1_ovf = ~accum_load_i[1] &
                    (sgn ? acc1_sum[52] ^ acc1_sum[51] : acc1_sum[52]);

  // Narrow: four add/sub stages and two sums.
  logic [211:0] nar;
  logic [52:0] nar_sum0;
  logic [52:0] nar_sum1;

  genvar gn;
  generate
    for (gn = 0; gn < 4; gn++)
    begin : g_nadd
      assign nar[53*gn +: 53] =
        addsub(ext53({18'h0, pipe_q[36*gn +: 18]}, 1'b0, sgn),
               ext53({18'h0, pipe_q[36*gn+18 +: 18]}, 1'b0, sgn),
               addsub_i[gn]);
    end
  endgenerate

  assign nar_sum0 = nar[52:0] + nar[105:53];
  assign nar_sum1 = nar[158:106] + nar[211:159];

  // Output selection; the wide product passes untouched.
  logic [52:0] res0_pick;
  logic [71:0] res0_d;
  logic [51:0] res1_d;
  logic mac_step;

  assign res0_pick = mac ? acc0_nx :
                     (arr == cmac_pkg::CMAC_ARR_MED) ? med_sum : nar_sum0;
  assign res0_d = (arr == cmac_pkg::CMAC_ARR_WIDE) ? pipe_q[71:0] :
                  {{19{res0_pick[52]}}, res0_pick};
  assign res1_d = mac ? acc1_nx[51:0] :
                  (arr == cmac_pkg::CMAC_ARR_NAR) ? nar_sum1[51:0] :
                  52'h0;
  assign mac_step = mac & stg_ce[cmac_pkg::CMAC_STG_OUT] &
                    ~stg_rst[cmac_pkg::CMAC_STG_OUT];

  // Output register stage; it is never bypassed, since the accumulator
  // feedback is taken from it.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      res0_q <= '0;
      res1_q <= '0;
    end
    else if (stg_rst[cmac_pkg::CMAC_STG_OUT])
    begin
      res0_q <= '0;
      res1_q <= '0;
    end
    else if (stg_ce[cmac_pkg::CMAC_STG_OUT])
    begin
      res0_q <= res0_d;
      res1_q <= res1_d;
    end
  end

  // Overflow outputs follow each accumulation step.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ovf0_q <= 1'b0;
      ovf1_q <= 1'b0;
    end
    else if (mac_step | ~mac)
    begin
      ovf0_q <= mac_step & acc0_ovf;
      ovf1_q <= mac_step & acc1_ovf;
    end
  end

  // Bus decode.
  logic addr_ok;
  logic wr_take;
  logic wr_now;
  logic stat_clr;
  logic [31:0] rd_val;
  logic [31:0] stat_val;

  assign addr_ok = hsel_i & hready_i & htrans_i[1];
  assign wr_take = addr_ok & hwrite_i & (hsize_i == 3'h2);
  assign wr_now = wr_pend_q & (wr_addr_q == cmac_pkg::CMAC_CTRL_OFS);
  assign stat_clr = wr_pend_q & (wr_addr_q == cmac_pkg::CMAC_STAT_OFS);

  assign stat_val = {25'h0, ovf1_st_q, ovf0_st_q, ref_q, 1'b0,
                     use_shift, arr};
  assign rd_val = (rd_addr_q == cmac_pkg::CMAC_CTRL_OFS) ? {16'h0, ctrl_q} :
                  (rd_addr_q == cmac_pkg::CMAC_STAT_OFS) ? stat_val :
                  (rd_addr_q == cmac_pkg::CMAC_RES0_OFS) ? res0_q[31:0] :
                  (rd_addr_q == cmac_pkg::CMAC_RES1_OFS) ? res1_q[31:0] :
                  32'h0;

  // Control register; a new arrangement takes effect on the next cycle.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ctrl_q <= cmac_pkg::CMAC_CTRL_RST;
    else if (wr_now)
      ctrl_q <= hwdata_i[15:0];
  end

  // Sticky flags: write one to clear; a new event wins.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ref_q <= 1'b0;
      ovf0_st_q <= 1'b0;
      ovf1_st_q <= 1'b0;
    end
    else
    begin
      ref_q <= refuse |
               (ref_q & ~(stat_clr & hwdata_i[cmac_pkg::CMAC_STAT_REF_BIT]));
      ovf0_st_q <= (mac_step & acc0_ovf) |
                   (ovf0_st_q &
                    ~(stat_clr & hwdata_i[cmac_pkg::CMAC_STAT_OVF0_BIT]));
      ovf1_st_q <= (mac_step & acc1_ovf) |
                   (ovf1_st_q &
                    ~(stat_clr & hwdata_i[cmac_pkg::CMAC_STAT_OVF1_BIT]));
    end
  end

  // Writes finish with no wait state; reads insert one wait state so that
  // read data comes from a register.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rd_addr_q <= '0;
      hrdata_q <= '0;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
      bus_q <= cmac_pkg::CMAC_BUS_IDLE;
    end
    else
    begin
      wr_pend_q <= wr_take;
      hresp_q <= 1'b0;
      if (wr_take)
        wr_addr_q <= haddr_i;
      case (bus_q)
        cmac_pkg::CMAC_BUS_IDLE:
          if (addr_ok & ~hwrite_i)
          begin
            rd_addr_q <= haddr_i;
            hready_q <= 1'b0;
            bus_q <= cmac_pkg::CMAC_BUS_RDWAIT;
          end
        cmac_pkg::CMAC_BUS_RDWAIT:
        begin
          hrdata_q <= rd_val;
          hready_q <= 1'b1;
          bus_q <= cmac_pkg::CMAC_BUS_IDLE;
        end
        default:
        begin
          hready_q <= 1'b1;
          bus_q <= cmac_pkg::CMAC_BUS_IDLE;
        end
      endcase
    end
  end

  // Outputs come straight from registers.
  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o = hresp_q;
  assign result0_o = res0_q;
  assign result1_o = res1_q;
  assign overflow0_o = ovf0_q;
  assign overflow1_o = ovf1_q;

endmodule

`default_nettype wire

// *** dv/cmac_top_assertions.sv ***
// Port-level checks for the multiply-accumulate slice.
// Assumes one AHB-Lite master whose hready is the slice's hreadyout_o.
`timescale 1ns/1ps
`default_nettype none

module cmac_top_assertions (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Bus.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Datapath.
  input wire logic [71:0] a_data_i,
  input wire logic [71:0] b_data_i,
  input wire logic ce_i,
  input wire logic [2:0] stage_ce_i,
  input wire logic [1:0] accum_load_i,
  input wire logic [51:0] load_value_port0_i,
  input wire logic [51:0] load_value_port1_i,
  input wire logic [71:0] result0_o,
  input wire logic [51:0] result1_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [15:0] ctrl_q;
  logic wr_q;
  logic [2:0] age_q;
  logic wt_w;
  logic ok_w;
  logic mac_w;
  logic [71:0] prod_w;
  // Checks wait until a new control word has reached every stage.
  assign wt_w = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  assign ok_w = age_q > 3'h3;
  assign mac_w = ok_w && ctrl_q[8:7] == 2'h0 && ctrl_q[5:4] == 2'h2
    && ctrl_q[1:0] == 2'h1;
  assign prod_w = {36'h0, a_data_i[35:0]} * {36'h0, b_data_i[35:0]};
  // Shadow of the control word, tracked from bus writes.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= cmac_pkg::CMAC_CTRL_RST;
      wr_q <= 1'b0;
      age_q <= 3'h0;
    end
    else
    begin
      wr_q <= wt_w && hsize_i == 3'h2 && haddr_i == cmac_pkg::CMAC_CTRL_OFS;
      if (wr_q)
        ctrl_q <= hwdata_i[15:0];
      age_q <= wr_q ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
    end
  end
  sequence rd_taken_s;
    hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  endsequence
  sequence one_wait_s;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  a_resp_okay:
    assert property (hresp_o == 1'b0) else $error("response not okay");
  a_read_wait:
    assert property (rd_taken_s |=> one_wait_s) else $error("read wait");
  a_write_nowait:
    assert property (wt_w |=> hreadyout_o) else $error("write stalled");
  a_rdata_hold:
    assert property (!$stable(hrdata_o) |-> !$past(hreadyout_o))
      else $error("rdata moved");
  a_wide_bare:
    assert property (ok_w && ctrl_q[8:0] == 9'h0 |->
      result0_o == $past(prod_w, 3)) else $error("wide product");
  a_load_acc0:
    assert property (mac_w && accum_load_i[0] |=>
      result0_o[51:0] == $past(load_value_port0_i)) else $error("load 0");
  a_load_acc1:
    assert property (mac_w && accum_load_i[1] |=>
      result1_o == $past(load_value_port1_i)) else $error("load 1");
  a_hold_basic:
    assert property (ok_w && ctrl_q[8:7] == 2'h1 && !ctrl_q[4] && !ce_i
      |=> $stable(result0_o) && $stable(result1_o)) else $error("ce hold");
  a_hold_stage:
    assert property (ok_w && ctrl_q[4] && !stage_ce_i[2] |=>
      $stable(result0_o)) else $error("stage hold");
endmodule

bind cmac_top cmac_top_assertions u_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .a_data_i(a_data_i), .b_data_i(b_data_i), .ce_i(ce_i),
  .stage_ce_i(stage_ce_i), .accum_load_i(accum_load_i),
  .load_value_port0_i(load_value_port0_i),
  .load_value_port1_i(load_value_port1_i),
  .result0_o(result0_o), .result1_o(result1_o)
);
`default_nettype wire

// *** dv/cmac_fabric.sv ***
// Fabric model that seeds both accumulators before a run.
// Assumes start_i is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

module cmac_fabric (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Request from the bench.
  input wire logic start_i,
  input wire logic [51:0] seed0_i,
  input wire logic [51:0] seed1_i,
  // Load path into the slice.
  output logic [1:0] accum_load_o,
  output logic [51:0] load_value0_o,
  output logic [51:0] load_value1_o
);
  // Values flip between loads to expose a wrong sampling edge.
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      accum_load_o <= 2'h0;
      load_value0_o <= 52'h0;
      load_value1_o <= 52'h0;
    end
    else
    begin
      accum_load_o <= {start_i, start_i};
      load_value0_o <= start_i ? seed0_i : ~load_value0_o;
      load_value1_o <= start_i ? seed1_i : ~load_value1_o;
    end
  end
endmodule
`default_nettype wire

// *** dv/test_configurable_multiply_accumulate.sv ***
// Self-checking bench for the multiply-accumulate slice.
// Assumes cmac_top, cmac_fabric and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_configurable_multiply_accumulate;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [71:0] a = 72'h0;
  logic [71:0] b = 72'h0;
  logic [17:0] sha = 18'h0;
  logic [17:0] shb = 18'h0;
  logic ce = 1'b1;
  logic [2:0] sce = 3'h7;
  logic [3:0] addsub = 4'h0;
  logic start = 1'b0;
  logic [51:0] v0 = 52'h0;
  logic [51:0] v1 = 52'h0;
  logic [31:0] hrdata, rd;
  logic hready;
  logic [1:0] ld;
  logic [51:0] lv0, lv1, r1, d0, d1;
  logic [71:0] r0, t;
  logic [31:0] cfg [3] = '{32'h4800, 32'h2401, 32'h1202};
  int wl [3] = '{36, 18, 9};
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;

  cmac_top uut (
    .ref_clk_i(clk), .reset_i(rst), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(), .a_data_i(a), .b_data_i(b),
    .shift_a_i(sha), .shift_b_i(shb), .dyn_shift_sel_i(1'b0),
    .ce_i(ce), .srst_i(1'b0), .stage_ce_i(sce), .stage_rst_i(3'h0),
    .addsub_i(addsub), .accum_load_i(ld), .load_value_port0_i(lv0),
    .load_value_port1_i(lv1), .result0_o(r0), .result1_o(r1),
    .overflow0_o(), .overflow1_o());
  cmac_fabric fab (.ref_clk_i(clk), .reset_i(rst), .start_i(start),
    .seed0_i(v0), .seed1_i(v1), .accum_load_o(ld),
    .load_value0_o(lv0), .load_value1_o(lv1));

  // Clock at 125 MHz.
  always #4 clk = ~clk;

  // Sum of n lane products of width w from lane k, unsigned.
  function automatic logic [71:0] f_sum(input logic [71:0] x,
    input logic [71:0] y, input int w, input int k, input int n);
    logic [71:0] m;
    logic [71:0] s;
    m = (72'h1 << w) - 72'h1;
    s = 72'h0;
    for (int i = k; i < k + n; i++)
      s += ((x >> (w * i)) & m) * ((y >> (w * i)) & m);
    return s;
  endfunction

  function automatic logic [71:0] rnd();
    return 72'({$urandom, $urandom, $urandom});
  endfunction

  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One AHB-Lite single transfer; the wait on hready has no fixed length.
  task automatic xfer(input logic w, input logic [31:0] ad,
    input logic [31:0] wd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [31:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0);
    chk({40'h0, rd}, {40'h0, exp});
  endtask

  task automatic summarize();
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cycle guard against hangs; also keeps the shift samples moving.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sha <= 18'($urandom);
    shb <= 18'($urandom);
    if (cyc == 3000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    void'($urandom(68));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(cmac_pkg::CMAC_CTRL_OFS, {16'h0, cmac_pkg::CMAC_CTRL_RST});
    xfer(1'b1, 32'h40, 32'hFFFF_FFFF);
    rdchk(32'h40, 32'h0);
    // Every arrangement in turn; all-ones operands first as the corner.
    for (int m = 0; m < 3; m++)
    begin
      xfer(1'b1, cmac_pkg::CMAC_CTRL_OFS, cfg[m]);
      for (int i = 0; i < 5; i++)
      begin
        @(posedge clk);
        a <= i == 0 ? {72{1'b1}} : rnd();
        b <= i == 0 ? {72{1'b1}} : rnd();
        repeat (3) @(posedge clk);
        #1;
        chk(r0, f_sum(a, b, wl[m], 0, m == 0 ? 1 : 4));
        chk({20'h0, r1}, m == 2 ? f_sum(a, b, 9, 4, 4) : 72'h0);
      end
    end
    // Seed both accumulators, then lane pair 0 subtracts and pair 1 adds.
    xfer(1'b1, cmac_pkg::CMAC_CTRL_OFS, 32'h2421);
    addsub <= 4'h1;
    a <= rnd();
    b <= rnd();
    t = rnd();
    v0 <= t[51:0];
    v1 <= t[71:20];
    repeat (3) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    #1;
    chk({20'h0, r0[51:0]}, {20'h0, v0});
    chk({20'h0, r1}, {20'h0, v1});
    t = f_sum(a, b, 18, 0, 1) - f_sum(a, b, 18, 1, 1);
    d0 = t[51:0];
    t = f_sum(a, b, 18, 2, 2);
    d1 = t[51:0];
    repeat (2) @(posedge clk);
    #1;
    chk({20'h0, r0[51:0]}, {20'h0, v0 + d0 + d0});
    chk({20'h0, r1}, {20'h0, v1 + d1 + d1});
    // Output frozen by the shared enable, then by its stage enable.
    for (int m = 0; m < 2; m++)
    begin
      xfer(1'b1, cmac_pkg::CMAC_CTRL_OFS, m == 0 ? 32'h24A1 : 32'h2431);
      ce <= (m == 1);
      sce <= m == 0 ? 3'h7 : 3'h3;
      a <= rnd();
      @(posedge clk);
      #1;
      t = r0;
      repeat (6) @(posedge clk);
      #1;
      chk(r0, t);
      ce <= 1'b1;
      sce <= 3'h7;
    end
    // Shift format: refused at 36 bits, taken at 16 bits.
    xfer(1'b1, cmac_pkg::CMAC_CTRL_OFS, 32'h4804);
    xfer(1'b1, cmac_pkg::CMAC_STAT_OFS, 32'h60);
    rdchk(cmac_pkg::CMAC_STAT_OFS, 32'h10);
    xfer(1'b1, cmac_pkg::CMAC_CTRL_OFS, 32'h2004);
    xfer(1'b1, cmac_pkg::CMAC_STAT_OFS, 32'h70);
    rdchk(cmac_pkg::CMAC_STAT_OFS, 32'h04);
    summarize();
  end
endmodule
`default_nettype wire
